// [ac_source_model.sv]
// Model of the AC source seen through the series resistor.
// Assumes a free running clk; flips the comparator decision while run.
`timescale 1ns/10ps
`default_nettype none
module ac_source_model
(
  input wire logic clk,
  input wire logic run,
  output logic sinkActive
);
  int cnt = 0;
  initial sinkActive = 1'b0;
  // Long half period so software can service each crossing
  always @(posedge clk)
  begin
    if (run && ++cnt == 40)
    begin
      cnt = 0;
      sinkActive <= ~sinkActive; // Changes just after the rising edge
    end
  end
endmodule
`default_nettype wire

// [zcd_pkg.sv]
// Constants for the zero-cross detector logic: register offsets, fields,
// reset values. Assumes a 32-bit Avalon-MM slave with word addressing.
// How it works
// - Pin above crossing threshold selects the current-sink action.
// - Pin below crossing threshold selects the current-source action.
// - Polarity off: logic output reads one when sinking, zero sourcing.
// - Polarity on: logic output inverted, high means source active.
// - Separate rising and falling edge detectors on adjusted output.
// - Crossing flag sets when an edge fires with its own enable.
// - Rise enable gates rising edges, fall enable gates falling ones.
// - Any change of the polarity bit raises an event, enabled or not.
// - Crossing flag stays set until software clears it.
// - Set wins over a clear arriving in the same cycle.
// - Enable at bit 7 hands the pin to the source/sink circuit.
// - Config bit clear: detector always active; set: enable needed.
// - Source/sink action and interrupts keep running in sleep.
// - Control: enable 7, output 5, polarity 4, rise 1, fall 0.
package zcd_pkg;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CLEAR = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_GLOBAL = 4'h4;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_OUTPUT = 5;
  localparam int BIT_POLARITY = 4;
  localparam int BIT_RISE = 1;
  localparam int BIT_FALL = 0;
  localparam int BIT_CROSS = 0;
  localparam int BIT_PERIPH = 1;
  localparam int BIT_GLOBAL = 0;
  localparam logic [31:0] CONTROL_WMASK = 32'h0000_0093;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
endpackage

// [zero_cross_detect_logic_tb_top.sv]
// Self-checking bench for zero_cross_detector with a behavioural model.
// Assumes ac_source_model supplies the analog decision.
`timescale 1ns/10ps
`default_nettype none
module zero_cross_detect_logic_tb_top
  import zcd_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, enReq = 1'b1, run = 1'b0;
  logic clkEn = 1'b1, heldDrive;
  logic read = 1'b0, write = 1'b0, waitrequest, sinkActive;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic pinOwned, sinkDrive, sourceDrive, crossOut, irq;
  int n_errors = 0, num_checks = 0, polarity_invert, rise, fall, expOut;
  always #4 clk = ~clk;
  zero_cross_detector i_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .enableRequired(enReq), .sinkActive(sinkActive), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .pinOwned(pinOwned),
    .sinkDrive(sinkDrive), .sourceDrive(sourceDrive),
    .crossingLogicOutput(crossOut), .irq(irq));
  ac_source_model i_src (.clk(clk), .run(run), .sinkActive(sinkActive));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input int d);
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog: the whole run needs well under 3000 cycles
  initial
  begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    void'($urandom(55699));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    bus(0, ADDR_CONTROL, 0);
    chk(q, 32'h0);
    bus(0, 4'h5, 0);
    chk(q, 32'h0);
    bus(1, ADDR_STATUS, 1);
    bus(0, ADDR_STATUS, 0);
    chk(q, 32'h0);
    // Polarity change with module disabled still flags an event
    bus(1, ADDR_CONTROL, 32'h10);
    repeat (20) @(posedge clk);
    bus(0, ADDR_STATUS, 0);
    chk(q, 32'h1);
    bus(1, ADDR_IRQ_ENABLE, 1);
    bus(1, ADDR_GLOBAL, 3);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    bus(1, ADDR_GLOBAL, 2);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    bus(1, ADDR_CLEAR, 1);
    bus(0, ADDR_STATUS, 0);
    chk(q, 32'h0);
    run <= 1'b1;
    // Random polarity and edge enables, one crossing per pass
    for (int i = 0; i < 12; i++)
    begin
      polarity_invert = $urandom % 2;
      rise = $urandom % 2;
      fall = $urandom % 2;
      bus(1, ADDR_CONTROL, 32'h80 | polarity_invert << 4 | rise << 1 | fall);
      repeat (4) @(posedge clk);
      bus(1, ADDR_CLEAR, 1);
      @(sinkActive);
      repeat (8) @(posedge clk);
      expOut = sinkActive ^ polarity_invert;
      chk(crossOut, expOut);
      chk(sinkDrive, sinkActive);
      chk(sourceDrive, !sinkActive);
      chk(pinOwned, 1'b1);
      bus(0, ADDR_STATUS, 0);
      chk(q, expOut ? rise : fall);
      bus(0, ADDR_CONTROL, 0);
      chk(q, 32'h80 | expOut << 5 | polarity_invert << 4 | rise << 1 | fall);
    end
    // Fuse clear: detector active without the enable bit
    run <= 1'b0;
    sys_rst <= 1'b1;
    enReq <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk(pinOwned, 1'b1);
    chk(sinkDrive, sinkActive);
    // Clock enable low freezes sinkDrive across a crossing
    heldDrive = sinkDrive;
    clkEn <= 1'b0;
    run <= 1'b1;
    @(sinkActive);
    repeat (4) @(posedge clk);
    chk(sinkDrive, heldDrive);
    clkEn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(sinkDrive, sinkActive);
    report_and_stop();
  end
endmodule
`default_nettype wire

// [zero_cross_detector.sv]
// Digital side of the zero-cross detector with an Avalon-MM slave.
// Assumes the analog comparator decision arrives asynchronously on
// sinkActive and the fuse bit enableRequired is static after reset.
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module zero_cross_detector
  import zcd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic enableRequired,
  input wire logic sinkActive,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic pinOwned,
  output logic sinkDrive,
  output logic sourceDrive,
  output logic crossingLogicOutput,
  output logic irq
);
  logic [7:0] control;
  logic syncA;
  logic syncB;
  logic prevOut;
  logic crossingIrqFlag;
  logic crossingIrqEnable;
  logic peripheralIrqEnable;
  logic globalIrqEnable;
  logic active;
  logic adjOut;
  logic riseEdge;
  logic fallEdge;
  logic polChange;
  logic setFlag;
  logic clearFlag;
  logic busDone;
  logic wrHit;
  logic [31:0] next_readdata;

  // Detector runs when fuse lets it, or when software enabled it
  assign active = !enableRequired || control[BIT_ENABLE];
  // Polarity applied to synchronised sink decision
  assign adjOut = syncB ^ control[BIT_POLARITY];
  assign riseEdge = adjOut && !prevOut;
  assign fallEdge = !adjOut && prevOut;
  // Writes land at the edge where waitrequest is sampled low
  assign wrHit = write && busDone && byteenable[0];
  assign polChange = wrHit && address == ADDR_CONTROL
    && writedata[BIT_POLARITY] != control[BIT_POLARITY];
  // Edge enables gate their own detector; polarity change needs no enable
  assign setFlag = (riseEdge && control[BIT_RISE])
    || (fallEdge && control[BIT_FALL]) || polChange;
  assign clearFlag = wrHit && address == ADDR_CLEAR
    && writedata[BIT_CROSS];

  // Two-stage synchroniser; first stage read only by the second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end
    else if (clkEn)
    begin
      syncA <= sinkActive;
      syncB <= syncA;
    end
  end

  // Edge history; a polarity flip raises polChange, then shows as one edge a cycle later
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prevOut <= 1'b0;
    else if (clkEn)
      prevOut <= adjOut;
  end

  // Control register writes, byte lane 0 only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      control <= CONTROL_RESET;
    else if (clkEn && wrHit && address == ADDR_CONTROL)
      control <= writedata[7:0] & CONTROL_WMASK[7:0];
  end

  // Enable registers for the interrupt chain
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      crossingIrqEnable <= 1'b0;
      peripheralIrqEnable <= 1'b0;
      globalIrqEnable <= 1'b0;
    end
    else if (clkEn && wrHit)
    begin
      if (address == ADDR_IRQ_ENABLE)
        crossingIrqEnable <= writedata[BIT_CROSS];
      if (address == ADDR_GLOBAL)
      begin
        peripheralIrqEnable <= writedata[BIT_PERIPH];
        globalIrqEnable <= writedata[BIT_GLOBAL];
      end
    end
  end

  // Sticky flag; set beats a same-cycle clear so no edge is lost
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      crossingIrqFlag <= 1'b0;
    else if (clkEn)
    begin
      if (setFlag)
        crossingIrqFlag <= 1'b1;
      else if (clearFlag)
        crossingIrqFlag <= 1'b0;
    end
  end

  // Pin drive and output bits; no sleep gating, so sleep is transparent
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pinOwned <= 1'b0;
      sinkDrive <= 1'b0;
      sourceDrive <= 1'b0;
      crossingLogicOutput <= 1'b0;
      irq <= 1'b0;
    end
    else if (clkEn)
    begin
      pinOwned <= active;
      sinkDrive <= active && sinkActive;
      sourceDrive <= active && !sinkActive;
      crossingLogicOutput <= adjOut;
      // Full chain of enables must be set to raise the line
      irq <= (crossingIrqFlag || setFlag) && crossingIrqEnable
        && peripheralIrqEnable && globalIrqEnable;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    unique case (address)
      ADDR_CONTROL:
      begin
        next_readdata[BIT_ENABLE] = control[BIT_ENABLE];
        next_readdata[BIT_OUTPUT] = adjOut;
        next_readdata[BIT_POLARITY] = control[BIT_POLARITY];
        next_readdata[BIT_RISE] = control[BIT_RISE];
        next_readdata[BIT_FALL] = control[BIT_FALL];
      end
      ADDR_STATUS: next_readdata[BIT_CROSS] = crossingIrqFlag;
      ADDR_IRQ_ENABLE: next_readdata[BIT_CROSS] = crossingIrqEnable;
      ADDR_GLOBAL:
      begin
        next_readdata[BIT_PERIPH] = peripheralIrqEnable;
        next_readdata[BIT_GLOBAL] = globalIrqEnable;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access: waitrequest drops in the second cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busDone <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      busDone <= (read || write) && !busDone;
      // Registered copy so the output comes straight from a flop
      waitrequest <= !((read || write) && !busDone);
      if (read && !busDone)
        readdata <= next_readdata;
    end
  end

  // Assertions
  chk_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && crossingIrqFlag && !clearFlag |=> crossingIrqFlag)
    else $error("crossing flag dropped without clear");
  chk_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && setFlag && clearFlag |=> crossingIrqFlag)
    else $error("clear beat a same-cycle set");
  chk_rise_sets: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && riseEdge && control[BIT_RISE] |=> crossingIrqFlag)
    else $error("enabled rising edge missed");
  chk_fall_gated: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && !crossingIrqFlag && fallEdge && !control[BIT_FALL]
    && !riseEdge && !polChange |=> !crossingIrqFlag)
    else $error("disabled falling edge set flag");
  chk_pol_event: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && polChange |=> crossingIrqFlag)
    else $error("polarity change gave no event");
  chk_sync_delay: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn [*3] |-> syncB == $past(sinkActive, 2))
    else $error("synchroniser depth wrong");
  chk_output_pol: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn |=> crossingLogicOutput == $past(syncB ^ control[BIT_POLARITY]))
    else $error("logic output polarity wrong");
  chk_drive_dir: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && active |=> sinkDrive == $past(sinkActive)
    && sourceDrive == !$past(sinkActive))
    else $error("sink/source choice wrong");
  chk_fuse_active: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn && !enableRequired |=> pinOwned)
    else $error("detector inactive with fuse clear");
  cov_rise: cover property (@(posedge clk) riseEdge && control[BIT_RISE]);
  cov_fall: cover property (@(posedge clk) fallEdge && control[BIT_FALL]);
  cov_race: cover property (@(posedge clk) setFlag && clearFlag);
  cov_irq: cover property (@(posedge clk) irq);
endmodule
`default_nettype wire
